/* pond_next_data.sv */
// Overview of operation
// - Shared A trigger: full byte at primary
// - Shared A: alternate reads ones, ignores writes
// - Split A: group 1 primary, group 0 alternate
// - Split A: unused nibbles read ones, unwritable
// - Shared B trigger: full byte at primary
// - Shared B: alternate reads ones, ignores writes
// - Split B: group 3 primary, group 2 alternate
// - Split B: primary high, alternate low nibble writable, rest ones
// - Group 3 bits stored, drive no pin
// - Group 2 match copies into port B
// - Enable A gates each port A copy
// - Enable B low nibble gates port B copy
// - Enable B high nibble plain storage
// - Reset clears all registers but trigger select, set to all ones; hardware standby all but read data
// - Enabled port bits read-only to software
// - Two-bit field picks timer channel
// - Layout chosen by comparing group selects
`timescale 1ns/1ps
`default_nettype none
`include "pond_consts.svh"

module pond_next_data #(
  parameter int ADDR_W = `POND_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hw_standby,
  input wire logic [`POND_CHANNELS-1:0] compare_match,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_q,
  output logic [7:0] port_a_out_data_q,
  output logic [7:0] port_b_out_data_q
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Bits of a next-data address that are live for a given layout;
  // used by both the write path and the read path of A and B
  function automatic pond_pkg::pond_byte_t pond_nd_mask(
    input logic share,
    input pond_pkg::pond_loc_e loc
  );
    pond_pkg::pond_byte_t m;
    m = `POND_MASK_NONE;
    if (share) begin
      if (loc == pond_pkg::POND_LOC_PRIMARY) begin
        m = `POND_MASK_ALL;
      end else begin
        m = `POND_MASK_NONE;
      end
    end else begin
      if (loc == pond_pkg::POND_LOC_PRIMARY) begin
        m = `POND_MASK_HI;
      end else begin
        m = `POND_MASK_LO;
      end
    end
    return m;
  endfunction

  // Merge written bits under a mask, keep the rest
  function automatic pond_pkg::pond_byte_t pond_merge(
    input pond_pkg::pond_byte_t old_v,
    input pond_pkg::pond_byte_t new_v,
    input pond_pkg::pond_byte_t mask
  );
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Read view: dead bits float to one
  function automatic pond_pkg::pond_byte_t pond_view(
    input pond_pkg::pond_byte_t v,
    input pond_pkg::pond_byte_t mask
  );
    return (v & mask) | ~mask;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pond_pkg::pond_byte_t trig_sel_q;
  pond_pkg::pond_byte_t next_enable_a_q;
  pond_pkg::pond_byte_t next_enable_b_q;
  pond_pkg::pond_byte_t next_data_a_q;
  pond_pkg::pond_byte_t next_data_b_q;
  pond_pkg::pond_byte_t next_data_a_d;
  pond_pkg::pond_byte_t next_data_b_d;
  pond_pkg::pond_byte_t port_a_d;
  pond_pkg::pond_byte_t port_b_d;
  pond_pkg::pond_byte_t rdata_d;

  // Reset and hardware standby act alike but for read data; software standby is
  // simply the absence of both, so contents survive it
  logic clear;
  assign clear = !resetn || hw_standby;

  // ----------------------------------------------------------------
  // Trigger steering
  // ----------------------------------------------------------------
  pond_trig_if tif ();

  assign tif.sel = trig_sel_q;
  assign tif.match = compare_match;

  pond_trigger u_trigger (
    .tif(tif.trg)
  );

  // Compare-match fire per group and layout flags
  logic [`POND_GROUPS-1:0] fire;
  logic share_a;
  logic share_b;
  assign fire = tif.fire;
  assign share_a = tif.share_a;
  assign share_b = tif.share_b;

  // ----------------------------------------------------------------
  // Write address decode
  // ----------------------------------------------------------------
  logic wr_trig;
  logic wr_en_a;
  logic wr_en_b;
  logic wr_nd_a_pri;
  logic wr_nd_a_alt;
  logic wr_nd_b_pri;
  logic wr_nd_b_alt;
  logic wr_port_a;
  logic wr_port_b;

  // One-hot strobes; any other address is a silent no-op
  always_comb begin
    wr_trig = 1'b0;
    wr_en_a = 1'b0;
    wr_en_b = 1'b0;
    wr_nd_a_pri = 1'b0;
    wr_nd_a_alt = 1'b0;
    wr_nd_b_pri = 1'b0;
    wr_nd_b_alt = 1'b0;
    wr_port_a = 1'b0;
    wr_port_b = 1'b0;
    if (!bus_wr) begin
      wr_trig = 1'b0;
    end else if (bus_addr == `POND_ADDR_TRIG_SEL) begin
      wr_trig = 1'b1;
    end else if (bus_addr == `POND_ADDR_EN_A) begin
      wr_en_a = 1'b1;
    end else if (bus_addr == `POND_ADDR_EN_B) begin
      wr_en_b = 1'b1;
    end else if (bus_addr == `POND_ADDR_ND_A_PRI) begin
      wr_nd_a_pri = 1'b1;
    end else if (bus_addr == `POND_ADDR_ND_A_ALT) begin
      wr_nd_a_alt = 1'b1;
    end else if (bus_addr == `POND_ADDR_ND_B_PRI) begin
      wr_nd_b_pri = 1'b1;
    end else if (bus_addr == `POND_ADDR_ND_B_ALT) begin
      wr_nd_b_alt = 1'b1;
    end else if (bus_addr == `POND_ADDR_PORT_A) begin
      wr_port_a = 1'b1;
    end else if (bus_addr == `POND_ADDR_PORT_B) begin
      wr_port_b = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger select register
  // ----------------------------------------------------------------

  // Defaults to channel 3 for every group
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      trig_sel_q <= `POND_RST_TRIG_SEL;
    end else if (wr_trig) begin
      trig_sel_q <= bus_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------

  // All eight enable A bits gate pins 7..0
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      next_enable_a_q <= `POND_RST_ZERO;
    end else if (wr_en_a) begin
      next_enable_a_q <= bus_wdata;
    end
  end

  // High nibble is kept as written though nothing uses it
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      next_enable_b_q <= `POND_RST_ZERO;
    end else if (wr_en_b) begin
      next_enable_b_q <= bus_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Next-data registers
  // ----------------------------------------------------------------

  // The layout flag follows the select register live, so a write
  // lands by the layout in force in that very cycle
  always_comb begin
    next_data_a_d = next_data_a_q;
    if (wr_nd_a_pri) begin
      next_data_a_d = pond_merge(next_data_a_q, bus_wdata,
                                 pond_nd_mask(share_a, pond_pkg::POND_LOC_PRIMARY));
    end else if (wr_nd_a_alt) begin
      next_data_a_d = pond_merge(next_data_a_q, bus_wdata,
                                 pond_nd_mask(share_a, pond_pkg::POND_LOC_ALTERNATE));
    end
  end

  // Same shape for B; the high nibble is group 3 storage only
  always_comb begin
    next_data_b_d = next_data_b_q;
    if (wr_nd_b_pri) begin
      next_data_b_d = pond_merge(next_data_b_q, bus_wdata,
                                 pond_nd_mask(share_b, pond_pkg::POND_LOC_PRIMARY));
    end else if (wr_nd_b_alt) begin
      next_data_b_d = pond_merge(next_data_b_q, bus_wdata,
                                 pond_nd_mask(share_b, pond_pkg::POND_LOC_ALTERNATE));
    end
  end

  // Next data A storage
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      next_data_a_q <= `POND_RST_ZERO;
    end else begin
      next_data_a_q <= next_data_a_d;
    end
  end

  // Next data B storage
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      next_data_b_q <= `POND_RST_ZERO;
    end else begin
      next_data_b_q <= next_data_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Transfer masks
  // ----------------------------------------------------------------
  logic [7:0] xfer_a;
  logic [7:0] xfer_b;

  genvar i;
  generate
    // Port A bits follow group 0 (low) or group 1 (high)
    for (i = 0; i < 8; i++) begin : g_xfer_a
      assign xfer_a[i] = fire[i / `POND_NIBBLE] & next_enable_a_q[i];
    end
    // Port B low nibble follows group 2; high nibble never moves,
    // since group 3 has no pins
    for (i = 0; i < 8; i++) begin : g_xfer_b
      if (i < `POND_NIBBLE) begin : g_pin
        assign xfer_b[i] = fire[`POND_PIN_GROUPS_A] & next_enable_b_q[i];
      end else begin : g_nopin
        assign xfer_b[i] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Port data registers
  // ----------------------------------------------------------------

  // Software reaches only bits not claimed by pulse output; the
  // transfer uses the next-data value held before this cycle
  always_comb begin
    port_a_d = port_a_out_data_q;
    if (wr_port_a) begin
      port_a_d = pond_merge(port_a_out_data_q, bus_wdata, ~next_enable_a_q);
    end
    port_a_d = pond_merge(port_a_d, next_data_a_q, xfer_a);
  end

  // Port B: low nibble pulse data, high nibble plain port bits
  always_comb begin
    port_b_d = port_b_out_data_q;
    if (wr_port_b) begin
      port_b_d = pond_merge(port_b_out_data_q, bus_wdata,
                            ~{4'h0, next_enable_b_q[3:0]});
    end
    port_b_d = pond_merge(port_b_d, next_data_b_q, xfer_b);
  end

  // Port A output flops
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      port_a_out_data_q <= `POND_RST_ZERO;
    end else begin
      port_a_out_data_q <= port_a_d;
    end
  end

  // Port B output flops
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      port_b_out_data_q <= `POND_RST_ZERO;
    end else begin
      port_b_out_data_q <= port_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Dead bits of a next-data address read as one
  always_comb begin
    rdata_d = `POND_RD_UNMAPPED;
    if (!bus_rd) begin
      rdata_d = `POND_RD_UNMAPPED;
    end else if (bus_addr == `POND_ADDR_TRIG_SEL) begin
      rdata_d = trig_sel_q;
    end else if (bus_addr == `POND_ADDR_EN_A) begin
      rdata_d = next_enable_a_q;
    end else if (bus_addr == `POND_ADDR_EN_B) begin
      rdata_d = next_enable_b_q;
    end else if (bus_addr == `POND_ADDR_ND_A_PRI) begin
      rdata_d = pond_view(next_data_a_q,
                          pond_nd_mask(share_a, pond_pkg::POND_LOC_PRIMARY));
    end else if (bus_addr == `POND_ADDR_ND_A_ALT) begin
      rdata_d = pond_view(next_data_a_q,
                          pond_nd_mask(share_a, pond_pkg::POND_LOC_ALTERNATE));
    end else if (bus_addr == `POND_ADDR_ND_B_PRI) begin
      rdata_d = pond_view(next_data_b_q,
                          pond_nd_mask(share_b, pond_pkg::POND_LOC_PRIMARY));
    end else if (bus_addr == `POND_ADDR_ND_B_ALT) begin
      rdata_d = pond_view(next_data_b_q,
                          pond_nd_mask(share_b, pond_pkg::POND_LOC_ALTERNATE));
    end else if (bus_addr == `POND_ADDR_PORT_A) begin
      rdata_d = port_a_out_data_q;
    end else if (bus_addr == `POND_ADDR_PORT_B) begin
      rdata_d = port_b_out_data_q;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bus_rdata_q <= `POND_RD_UNMAPPED;
    end else begin
      bus_rdata_q <= rdata_d;
    end
  end

endmodule // pond_next_data

`default_nettype wire

/* pond_consts.svh */
`ifndef POND_CONSTS_SVH
`define POND_CONSTS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define POND_ADDR_W 16
`define POND_DATA_W 8

// ----------------------------------------------------------------
// Register byte addresses (low 16 bits)
// ----------------------------------------------------------------
`define POND_ADDR_TRIG_SEL 16'hFFA1
`define POND_ADDR_EN_B 16'hFFA2
`define POND_ADDR_EN_A 16'hFFA3
`define POND_ADDR_ND_B_PRI 16'hFFA4
`define POND_ADDR_ND_A_PRI 16'hFFA5
`define POND_ADDR_ND_B_ALT 16'hFFA6
`define POND_ADDR_ND_A_ALT 16'hFFA7
`define POND_ADDR_PORT_A 16'hFFD3
`define POND_ADDR_PORT_B 16'hFFD6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POND_RST_ZERO 8'h00
`define POND_RST_TRIG_SEL 8'hFF
`define POND_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Byte masks for the next-data windows
// ----------------------------------------------------------------
`define POND_MASK_ALL 8'hFF
`define POND_MASK_HI 8'hF0
`define POND_MASK_LO 8'h0F
`define POND_MASK_NONE 8'h00

// ----------------------------------------------------------------
// Trigger layout
// ----------------------------------------------------------------
`define POND_GROUPS 4
`define POND_SEL_W 2
`define POND_CHANNELS 4
`define POND_PIN_GROUPS_A 2
`define POND_NIBBLE 4

`endif

/* pond_pkg.sv */
`default_nettype none

package pond_pkg;
  // Register byte as seen on the bus
  typedef logic [7:0] pond_byte_t;
  // Which of the two addresses of a next-data pair is touched
  typedef enum logic {
    POND_LOC_PRIMARY,
    POND_LOC_ALTERNATE
  } pond_loc_e;
endpackage

`default_nettype wire

/* pond_trig_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pond_consts.svh"

// ----------------------------------------------------------------
// Trigger selection carrier
// ----------------------------------------------------------------
interface pond_trig_if;
  logic [7:0] sel;
  logic [`POND_CHANNELS-1:0] match;
  logic [`POND_GROUPS-1:0] fire;
  logic share_a;
  logic share_b;
  modport ctl (output sel, output match, input fire, input share_a, input share_b);
  modport trg (input sel, input match, output fire, output share_a, output share_b);
endinterface // pond_trig_if

`default_nettype wire

/* pond_trigger.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pond_consts.svh"

module pond_trigger (
  pond_trig_if.trg tif
);
  // ----------------------------------------------------------------
  // Per-group compare-match steering
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `POND_GROUPS; g++) begin : g_grp
      // Two-bit code picks timer channel 0..3
      assign tif.fire[g] = tif.match[tif.sel[`POND_SEL_W*g +: `POND_SEL_W]];
    end
  endgenerate

  // Pairs sharing one trigger collapse onto one address
  assign tif.share_a = (tif.sel[1:0] == tif.sel[3:2]);
  assign tif.share_b = (tif.sel[5:4] == tif.sel[7:6]);
endmodule // pond_trigger

`default_nettype wire

/* pond_next_data_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pond_consts.svh"

module pond_next_data_sva #(
  parameter int ADDR_W = `POND_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hw_standby,
  input wire logic [3:0] compare_match,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata_q,
  input wire logic [7:0] port_a_out_data_q,
  input wire logic [7:0] port_b_out_data_q
);
  logic [7:0] sel_q;
  logic [7:0] en_a_q;
  logic [7:0] en_b_q;
  logic sh_a;
  logic sh_b;
  logic wr_pa;
  logic wr_pb;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Shadow copies of the controls; standby clears them like reset
  always_ff @(posedge ref_clk) begin
    if (!resetn || hw_standby) begin
      sel_q <= 8'hFF;
      en_a_q <= 8'h00;
      en_b_q <= 8'h00;
    end else if (bus_wr) begin
      if (bus_addr == `POND_ADDR_TRIG_SEL) sel_q <= bus_wdata;
      if (bus_addr == `POND_ADDR_EN_A) en_a_q <= bus_wdata;
      if (bus_addr == `POND_ADDR_EN_B) en_b_q <= bus_wdata;
    end
  end

  // Layout follows equal selects of each group pair
  assign sh_a = sel_q[1:0] == sel_q[3:2];
  assign sh_b = sel_q[5:4] == sel_q[7:6];
  assign wr_pa = bus_wr && bus_addr == `POND_ADDR_PORT_A;
  assign wr_pb = bus_wr && bus_addr == `POND_ADDR_PORT_B;

  // ----
  // Checks
  // ----
  a_rd_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata_q == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_rd: assert property (bus_rd && bus_addr[15:8] != 8'hFF |=> bus_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_alt_a_ones: assert property (bus_rd && sh_a && bus_addr == `POND_ADDR_ND_A_ALT |=> bus_rdata_q == 8'hFF)
    else $error("shared A alternate not ones");
  a_split_a_ones: assert property (bus_rd && !sh_a && bus_addr == `POND_ADDR_ND_A_PRI |=> bus_rdata_q[3:0] == 4'hF)
    else $error("split A primary low not ones");
  a_alt_b_ones: assert property (bus_rd && sh_b && bus_addr == `POND_ADDR_ND_B_ALT |=> bus_rdata_q == 8'hFF)
    else $error("shared B alternate not ones");
  a_split_b_ones: assert property (bus_rd && !sh_b && bus_addr == `POND_ADDR_ND_B_ALT |=> bus_rdata_q[7:4] == 4'hF)
    else $error("split B alternate high not ones");
  a_en_b_store: assert property (bus_rd && !hw_standby && bus_addr == `POND_ADDR_EN_B |=> bus_rdata_q == $past(en_b_q))
    else $error("enable B readback wrong");
  a_stby_clear: assert property (hw_standby |=> port_a_out_data_q == 8'h00 && port_b_out_data_q == 8'h00)
    else $error("standby did not clear ports");
  a_port_a_ro: assert property (wr_pa && compare_match == 4'h0 && !hw_standby
    |=> ((port_a_out_data_q ^ $past(port_a_out_data_q)) & $past(en_a_q)) == 8'h00)
    else $error("enabled port A bit written");
  a_grp3_silent: assert property (!wr_pb && !hw_standby |=> $stable(port_b_out_data_q[7:4]))
    else $error("port B high bits moved");
  a_quiet_hold: assert property (compare_match == 4'h0 && !bus_wr && !hw_standby
    |=> $stable(port_a_out_data_q) && $stable(port_b_out_data_q))
    else $error("port changed without cause");
endmodule // pond_next_data_sva

bind pond_next_data pond_next_data_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk(ref_clk), .resetn(resetn),
  .hw_standby(hw_standby), .compare_match(compare_match), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .port_a_out_data_q(port_a_out_data_q),
  .port_b_out_data_q(port_b_out_data_q));

`default_nettype wire

/* pond_match_src.sv */
`timescale 1ns/1ps
`default_nettype none

module pond_match_src (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] trig,
  output logic [3:0] compare_match
);
  // Compare pulse repeats each request one cycle later, as long as it; silent while timers reset
  always_ff @(posedge ref_clk) begin
    compare_match <= resetn ? trig : 4'h0;
  end
endmodule // pond_match_src

`default_nettype wire

/* pond_next_data_test.sv */
`timescale 1ns/1ps
`default_nettype none

module pond_next_data_test;
  logic ref_clk;
  logic resetn;
  logic hw_standby;
  logic [3:0] trig;
  logic [3:0] compare_match;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata_q;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [7:0] exp_a;
  logic [1:0] k;
  int num_errors;
  int num_checks;
  int cyc;
  // Rows: trigger select, address, write data, read-back
  logic [39:0] rows [11] = '{40'hFF_FFA5_5A_5A, 40'hFF_FFA7_00_FF, 40'hFF_FFA4_C3_C3,
    40'hFF_FFA6_00_FF, 40'hFE_FFA5_9F_9F, 40'hFE_FFA7_76_F6, 40'hBE_FFA4_5A_5F,
    40'hBE_FFA6_3E_FE, 40'hFF_FFA2_F5_F5, 40'hFF_FFA3_0F_0F, 40'hFF_1234_77_00};

  pond_next_data dut (.ref_clk(ref_clk), .resetn(resetn), .hw_standby(hw_standby),
    .compare_match(compare_match), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .port_a_out_data_q(pa), .port_b_out_data_q(pb));
  pond_match_src u_src (.ref_clk(ref_clk), .resetn(resetn), .trig(trig), .compare_match(compare_match));

  // ----
  // Helpers
  // ----
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] e);
    num_checks++;
    if (got !== e) begin
      $display("BAD %0t got %h want %h", $time, got, e);
      num_errors++;
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata_q, e);
  endtask

  // Pulse reaches the block one cycle late, port moves one after that
  task fire(input int ch);
    @(posedge ref_clk);
    trig <= 4'h1 << ch;
    @(posedge ref_clk);
    trig <= 4'h0;
    @(posedge ref_clk);
    #1;
  endtask

  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up;
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    resetn = 1'b0;
    hw_standby = 1'b0;
    trig = 4'h0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(16'hFFA1, 8'hFF);
    rd(16'hFFA5, 8'h00);
    rd(16'hFFA4, 8'h00);
    chk(pa | pb, 8'h00);
    for (int i = 0; i < 11; i++) begin
      wr(16'hFFA1, rows[i][39:32]);
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], rows[i][7:0]);
    end
    rd(16'hFFA5, 8'h96);
    rd(16'hFFA4, 8'h5E);
    wr(16'hFFD3, 8'hFF);
    chk(pa, 8'hF0);
    wr(16'hFFD6, 8'hFF);
    chk(pb, 8'hFA);
    fire(3);
    chk(pa, 8'hF6);
    chk(pb, 8'hFE);
    exp_a = 8'hF6;
    // Every select code, with a wrong channel first
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      wr(16'hFFA1, {k, k, k, k});
      wr(16'hFFA3, 8'hFF);
      wr(16'hFFA5, {k, ~k, k, ~k});
      fire((c + 1) % 4);
      chk(pa, exp_a);
      fire(c);
      exp_a = {k, ~k, k, ~k};
      chk(pa, exp_a);
    end
    // Write and match at one edge: old next data goes out
    fork
      fire(3);
      begin
        @(posedge ref_clk);
        wr(16'hFFA5, 8'h11);
      end
    join
    chk(pa, 8'hCC);
    fire(3);
    chk(pa, 8'h11);
    @(posedge ref_clk);
    hw_standby <= 1'b1;
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    #1 chk(pa | pb, 8'h00);
    rd(16'hFFA3, 8'h00);
    rd(16'hFFA5, 8'h00);
    // Every group on its own channel: only that group may move
    wr(16'hFFA1, 8'hE4);
    wr(16'hFFA3, 8'hFF);
    wr(16'hFFA2, 8'h0F);
    wr(16'hFFA5, 8'hA0);
    wr(16'hFFA7, 8'h05);
    wr(16'hFFA6, 8'h0C);
    fire(1);
    chk(pa, 8'hA0);
    fire(2);
    chk(pb, 8'h0C);
    fire(0);
    chk(pa, 8'hA5);
    fire(3);
    chk(pb, 8'h0C);
    // Reset in mid-run clears ports and enable B, and returns the trigger select to FF
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b1;
    #1 chk(pa | pb, 8'h00);
    rd(16'hFFA1, 8'hFF);
    rd(16'hFFA2, 8'h00);
    wrap_up;
  end
endmodule // pond_next_data_test

`default_nettype wire
